// ### stic_pkg.sv
// shared constants for the sync transmit idle and modem interrupt control block
package stic_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int NUM_MODEM = 5;
    localparam int TXERR_W = 3;
    // register byte offsets
    localparam logic [7:0] OFF_CSR = 8'h00;
    localparam logic [7:0] OFF_CHG = 8'h04;
    localparam logic [7:0] OFF_MODEM = 8'h08;
    localparam logic [7:0] OFF_TXERR = 8'h0C;
    // csr field positions
    localparam int BIT_IDLE = 3;
    localparam int BIT_DS_IE = 4;
    localparam int BIT_TX_IE = 5;
    localparam int BIT_DS_CHG = 6;
    localparam int BIT_DONE_SEC = 7;
    localparam int BIT_TX_ERR = 14;
    localparam int BIT_DONE_PRI = 15;
    // reset values
    localparam logic [15:0] CSR_RESET = 16'h0000;
    localparam logic [4:0] MODEM_RESET = 5'h00;
    // line idle pattern selection
    typedef enum logic [1:0] {
        IDLE_MARK = 2'b00,
        IDLE_SYNC = 2'b01,
        IDLE_FLAG = 2'b10
    } stic_idle_t;
endpackage

// ### stic_sync2.sv
// two flip-flop synchroniser for a bundle of level inputs
`timescale 1ns/1ps
module stic_sync2 #(
    parameter int W = 5
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] q_next;

    // elaboration check: a zero-width bundle has nothing to carry
    if (W < 1) begin : g_bad_width
        $error("stic_sync2: width must be at least one");
    end

    always_comb begin
        meta_next = d;
        q_next = meta_reg;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= meta_next;
            q <= q_next;
        end
    end
endmodule

// ### stic_top.sv
// sync transmit control/status: idle control, modem change and transmit irq
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
// What this block does
// - byte protocol idles sync or mark per bit
// - bit protocol idles mark or flags per bit
// - cleared enable after success may leave mark
// - idle bit read/write, cleared by reset/init
// - modem enable and change flag raise irq
// - transmit enable gates done and error irqs
// - any modem line toggle sets change flag
// - per-line change flags readable by software
// - change flag read-only, cleared by modem read
// - transmit error is OR of three errors
module stic_top (
    input wire logic clk,
    input wire logic rstn,
    input wire logic init,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [stic_pkg::ADDR_W-1:0] paddr,
    input wire logic [stic_pkg::DATA_W-1:0] pwdata,
    output logic [stic_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [stic_pkg::NUM_MODEM-1:0] modem_in,
    input wire logic bit_oriented,
    input wire logic tx_enable,
    input wire logic msg_active,
    input wire logic last_msg_ok,
    input wire logic done_pri_set,
    input wire logic done_sec_set,
    input wire logic done_pri_clr,
    input wire logic done_sec_clr,
    input wire logic [stic_pkg::TXERR_W-1:0] tx_err_set,
    output logic [1:0] idle_sel,
    output logic tx_irq
);
    import stic_pkg::*;

    // ========================================================
    // modem line synchroniser
    // lines are asynchronous to clk
    logic [NUM_MODEM-1:0] modem_s;

    stic_sync2 #(.W(NUM_MODEM)) u_sync (
        .clk(clk),
        .rstn(rstn),
        .d(modem_in),
        .q(modem_s)
    );

    // ========================================================
    // state
    logic idle_reg, idle_next;
    logic ds_ie_reg, ds_ie_next;
    logic tx_ie_reg, tx_ie_next;
    logic ds_chg_reg, ds_chg_next;
    logic done_pri_reg, done_pri_next;
    logic done_sec_reg, done_sec_next;
    logic [TXERR_W-1:0] txerr_reg, txerr_next;
    logic [NUM_MODEM-1:0] chg_reg, chg_next;
    logic [NUM_MODEM-1:0] modem_prev_reg, modem_prev_next;
    logic prev_valid_reg, prev_valid_next;
    logic [1:0] fill_reg, fill_next;
    logic hold_mark_reg, hold_mark_next;
    logic tx_en_prev_reg, tx_en_prev_next;
    logic [DATA_W-1:0] prdata_next;
    logic pready_next, pslverr_next;
    logic [1:0] idle_sel_next;
    logic tx_irq_next;

    logic clr_all, acc, wr, rd, mapped;
    logic [NUM_MODEM-1:0] toggled;
    logic tx_err_flag;
    logic [15:0] csr_view;

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        return (a == OFF_CSR) || (a == OFF_CHG) || (a == OFF_MODEM) || (a == OFF_TXERR);
    endfunction

    // ========================================================
    // next state
    always_comb begin
        // bus init clears the register, flag and hold bits, not the change-detect history or the bus outputs
        clr_all = init;
        // one wait state: acc is the first access cycle, pready answers it
        acc = psel && penable && !pready;
        // a write lands only on the edge where the master sees pready high
        wr = psel && penable && pready && pwrite;
        rd = acc && !pwrite;
        mapped = is_mapped(paddr);
        tx_err_flag = |txerr_reg;
        csr_view = CSR_RESET;
        csr_view[BIT_IDLE] = idle_reg;
        csr_view[BIT_DS_IE] = ds_ie_reg;
        csr_view[BIT_TX_IE] = tx_ie_reg;
        csr_view[BIT_DS_CHG] = ds_chg_reg;
        csr_view[BIT_DONE_SEC] = done_sec_reg;
        csr_view[BIT_TX_ERR] = tx_err_flag;
        csr_view[BIT_DONE_PRI] = done_pri_reg;

        idle_next = idle_reg;
        ds_ie_next = ds_ie_reg;
        tx_ie_next = tx_ie_reg;
        if (wr && paddr == OFF_CSR) begin
            idle_next = pwdata[BIT_IDLE];
            ds_ie_next = pwdata[BIT_DS_IE];
            tx_ie_next = pwdata[BIT_TX_IE];
        end

        // change detection only after a valid previous sample
        modem_prev_next = modem_s;
        // synchroniser shows its reset zeros for two edges; comparing against
        // them would fake a change on every line that idles on
        fill_next = {fill_reg[0], 1'b1};
        prev_valid_next = fill_reg[1];
        toggled = prev_valid_reg ? (modem_s ^ modem_prev_reg) : '0;
        chg_next = chg_reg | toggled;
        ds_chg_next = ds_chg_reg;
        // reading the modem register clears; a new toggle wins over the clear
        if (rd && paddr == OFF_MODEM) begin
            ds_chg_next = 1'b0;
            chg_next = toggled;
        end
        if (|toggled) begin
            ds_chg_next = 1'b1;
        end

        // set wins over a clear in the same cycle
        done_pri_next = (done_pri_reg && !done_pri_clr) || done_pri_set;
        done_sec_next = (done_sec_reg && !done_sec_clr) || done_sec_set;
        txerr_next = txerr_reg;
        if (rd && paddr == OFF_TXERR) begin
            txerr_next = '0;
        end
        txerr_next = txerr_next | tx_err_set;

        // enable dropped right after a good message: hold mark until re-enabled
        tx_en_prev_next = tx_enable;
        hold_mark_next = hold_mark_reg;
        if (tx_en_prev_reg && !tx_enable && last_msg_ok && !msg_active) begin
            hold_mark_next = 1'b1;
        end else if (tx_enable) begin
            hold_mark_next = 1'b0;
        end

        if (hold_mark_next || msg_active) begin
            idle_sel_next = IDLE_MARK;
        end else if (bit_oriented) begin
            idle_sel_next = idle_reg ? IDLE_FLAG : IDLE_MARK;
        end else begin
            idle_sel_next = idle_reg ? IDLE_MARK : IDLE_SYNC;
        end

        // built from next values so the request moves with its flag
        tx_irq_next = (ds_ie_next && ds_chg_next)
            || (tx_ie_next && (done_pri_next || done_sec_next || (|txerr_next)));

        pready_next = acc;
        // unmapped: error answer, read zero, write dropped
        pslverr_next = acc && !mapped;
        prdata_next = '0;
        if (rd) begin
            unique case (paddr)
                OFF_CSR: prdata_next = {16'h0000, csr_view};
                OFF_CHG: prdata_next = {27'h0000000, chg_reg};
                OFF_MODEM: prdata_next = {27'h0000000, modem_s};
                OFF_TXERR: prdata_next = {29'h00000000, txerr_reg};
                default: prdata_next = '0;
            endcase
        end

        if (clr_all) begin
            idle_next = 1'b0;
            ds_ie_next = 1'b0;
            tx_ie_next = 1'b0;
            ds_chg_next = 1'b0;
            chg_next = '0;
            done_pri_next = 1'b0;
            done_sec_next = 1'b0;
            txerr_next = '0;
            hold_mark_next = 1'b0;
            tx_irq_next = 1'b0;
        end
    end

    // ========================================================
    // registers
    always_ff @(posedge clk) begin
        if (!rstn) begin
            idle_reg <= 1'b0;
            ds_ie_reg <= 1'b0;
            tx_ie_reg <= 1'b0;
            ds_chg_reg <= 1'b0;
            done_pri_reg <= 1'b0;
            done_sec_reg <= 1'b0;
            txerr_reg <= '0;
            chg_reg <= MODEM_RESET;
            modem_prev_reg <= MODEM_RESET;
            prev_valid_reg <= 1'b0;
            fill_reg <= 2'h0;
            hold_mark_reg <= 1'b0;
            tx_en_prev_reg <= 1'b0;
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            // default matches a cleared idle bit in byte mode
            idle_sel <= IDLE_SYNC;
            tx_irq <= 1'b0;
        end else begin
            idle_reg <= idle_next;
            ds_ie_reg <= ds_ie_next;
            tx_ie_reg <= tx_ie_next;
            ds_chg_reg <= ds_chg_next;
            done_pri_reg <= done_pri_next;
            done_sec_reg <= done_sec_next;
            txerr_reg <= txerr_next;
            chg_reg <= chg_next;
            modem_prev_reg <= modem_prev_next;
            prev_valid_reg <= prev_valid_next;
            fill_reg <= fill_next;
            hold_mark_reg <= hold_mark_next;
            tx_en_prev_reg <= tx_en_prev_next;
            prdata <= prdata_next;
            pready <= pready_next;
            pslverr <= pslverr_next;
            idle_sel <= idle_sel_next;
            tx_irq <= tx_irq_next;
        end
    end

    // ========================================================
    // checks: line idle state
    a_idle_byte_mode: assert property (@(posedge clk) disable iff (!rstn)
        (!bit_oriented && !msg_active && !hold_mark_next && !init && !idle_reg)
        |=> idle_sel == IDLE_SYNC) else $error("byte idle not sync");

    a_idle_byte_mark: assert property (@(posedge clk) disable iff (!rstn)
        (!bit_oriented && !init && idle_reg)
        |=> idle_sel == IDLE_MARK) else $error("byte idle not mark");

    a_idle_bit_mode: assert property (@(posedge clk) disable iff (!rstn)
        (bit_oriented && !msg_active && !hold_mark_next && !init && idle_reg)
        |=> idle_sel == IDLE_FLAG) else $error("bit idle not flag");

    a_idle_bit_mark: assert property (@(posedge clk) disable iff (!rstn)
        (bit_oriented && !init && !idle_reg)
        |=> idle_sel == IDLE_MARK) else $error("bit idle not mark");

    a_hold_mark: assert property (@(posedge clk) disable iff (!rstn)
        hold_mark_reg && !tx_enable && !init
        |-> ##1 idle_sel == IDLE_MARK) else $error("mark not held");

    // ========================================================
    // checks: register bits and modem change
    a_idle_clear: assert property (@(posedge clk) disable iff (!rstn)
        init |=> !idle_reg && !ds_ie_reg && !tx_ie_reg) else $error("init kept bits");

    a_idle_write: assert property (@(posedge clk) disable iff (!rstn)
        wr && paddr == OFF_CSR && pwdata[BIT_IDLE] && !init
        |=> idle_reg) else $error("idle bit not written");

    a_toggle_sets: assert property (@(posedge clk) disable iff (!rstn)
        prev_valid_reg && !init && (modem_s != modem_prev_reg)
        |=> ds_chg_reg) else $error("toggle lost");

    a_chg_record: assert property (@(posedge clk) disable iff (!rstn)
        ds_chg_reg |-> (chg_reg != '0) || $past(rd)) else $error("change not recorded");

    a_chg_line: assert property (@(posedge clk) disable iff (!rstn)
        prev_valid_reg && !init && (modem_s[0] != modem_prev_reg[0])
        |=> chg_reg[0]) else $error("line change not recorded");

    a_chg_read_clr: assert property (@(posedge clk) disable iff (!rstn)
        rd && paddr == OFF_MODEM && !(|toggled) |=> !ds_chg_reg) else $error("no clear");

    // ========================================================
    // checks: transmit vector request
    a_modem_irq: assert property (@(posedge clk) disable iff (!rstn)
        ds_ie_reg && ds_chg_reg && !init && !(psel && penable)
        |=> tx_irq) else $error("modem irq missing");

    a_tx_irq: assert property (@(posedge clk) disable iff (!rstn)
        tx_ie_reg && !init && !(psel && penable) && !done_pri_clr && $rose(done_pri_reg)
        |=> tx_irq) else $error("done irq missing");

    a_err_irq: assert property (@(posedge clk) disable iff (!rstn)
        tx_ie_reg && !init && !(psel && penable) && (|tx_err_set)
        |=> tx_irq) else $error("error irq missing");

    a_irq_quiet: assert property (@(posedge clk) disable iff (!rstn)
        !ds_ie_reg && !tx_ie_reg && !(psel && penable)
        |=> !tx_irq) else $error("irq without enable");

    a_init_quiet: assert property (@(posedge clk) disable iff (!rstn)
        init |=> !tx_irq && !ds_chg_reg) else $error("init kept irq");
endmodule

// ### stic_modem_model.sv
// behavioural data set driving the five modem status lines
`timescale 1ns/1ps
module stic_modem_model #(
    parameter logic [4:0] INIT_LINES = 5'h0A
) (
    input wire logic clk,
    input wire logic [stic_pkg::NUM_MODEM-1:0] flip,
    output logic [stic_pkg::NUM_MODEM-1:0] lines
);
    import stic_pkg::*;
    // lines change only after a clock edge, like a real slow data set
    initial lines = INIT_LINES;
    always @(posedge clk) begin
        lines <= lines ^ flip;
    end
endmodule

// ### test_stic_top.sv
// apb testbench for the sync transmit idle and modem interrupt block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module test_stic_top;
    import stic_pkg::*;
    logic clk = 0, rstn = 0, init = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, e, tx_irq;
    logic bit_oriented = 0, tx_enable = 1, msg_active = 0, last_msg_ok = 1;
    logic done_pri_set = 0, done_sec_set = 0, done_pri_clr = 0, done_sec_clr = 0;
    logic [2:0] tx_err_set = 3'h0;
    logic [4:0] flip = 5'h00, modem_in, exp_lines = 5'h0A;
    logic [1:0] idle_sel;
    logic [1:0] idle_tab [4] = '{IDLE_SYNC, IDLE_MARK, IDLE_MARK, IDLE_FLAG};
    int error_cnt = 0, n_checks = 0;
    always #2 clk = ~clk;
    stic_modem_model #(.INIT_LINES(5'h0A)) stic_modem_model_i (.clk(clk), .flip(flip),
        .lines(modem_in));
    stic_top stic_top_i (.clk(clk), .rstn(rstn), .init(init), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .modem_in(modem_in), .bit_oriented(bit_oriented),
        .tx_enable(tx_enable), .msg_active(msg_active), .last_msg_ok(last_msg_ok),
        .done_pri_set(done_pri_set), .done_sec_set(done_sec_set),
        .done_pri_clr(done_pri_clr), .done_sec_clr(done_sec_clr),
        .tx_err_set(tx_err_set), .idle_sel(idle_sel), .tx_irq(tx_irq));
    // ==========================================
    // bus tasks
    task give_verdict;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            error_cnt++;
            give_verdict();
        end
        r = prdata;
        e = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        apb(0, a, 32'h0);
        `CHK(nm, exp, r)
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // ==========================================
    // tests
    initial begin
        tick(10);
        rstn <= 1;
        rd(OFF_CSR, 32'h0, "csr reset");
        `CHK("idle reset", IDLE_SYNC, idle_sel)
        apb(1, OFF_CSR, 32'h00000078);
        rd(OFF_CSR, 32'h00000038, "csr rw");
        for (int i = 0; i < 4; i++) begin
            bit_oriented <= i[1];
            apb(1, OFF_CSR, i[0] ? 32'h8 : 32'h0);
            tick(2);
            `CHK("idle sel", idle_tab[i], idle_sel)
        end
        bit_oriented <= 0;
        apb(1, OFF_CSR, 32'h00000000);
        last_msg_ok <= 0;
        tx_enable <= 0;
        tick(3);
        `CHK("no hold", IDLE_SYNC, idle_sel)
        tx_enable <= 1;
        last_msg_ok <= 1;
        tick(2);
        tx_enable <= 0;
        tick(3);
        `CHK("hold mark", IDLE_MARK, idle_sel)
        tx_enable <= 1;
        tick(3);
        `CHK("mark end", IDLE_SYNC, idle_sel)
        msg_active <= 1;
        tick(3);
        `CHK("msg mark", IDLE_MARK, idle_sel)
        msg_active <= 0;
        $display("test idle done");
        for (int i = 0; i < 6; i++) begin
            apb(1, OFF_CSR, i < 5 ? 32'h10 : 32'h0);
            flip <= 5'h01 << (i % 5);
            exp_lines = exp_lines ^ (5'h01 << (i % 5));
            @(posedge clk) flip <= 5'h00;
            tick(8);
            `CHK("modem irq", i < 5, tx_irq)
            rd(OFF_CHG, 32'h1 << (i % 5), "chg lines");
            rd(OFF_CSR, i < 5 ? 32'h50 : 32'h40, "chg bit");
            rd(OFF_MODEM, {27'h0, exp_lines}, "modem rx");
            rd(OFF_CSR, i < 5 ? 32'h10 : 32'h0, "chg clr");
            rd(OFF_CHG, 32'h0, "lines clr");
            `CHK("modem irq off", 1'b0, tx_irq)
        end
        $display("test modem done");
        apb(1, OFF_CSR, 32'h20);
        for (int k = 0; k < 5; k++) begin
            @(posedge clk);
            done_pri_set <= (k == 0); done_sec_set <= (k == 1);
            tx_err_set <= (k > 1) ? 3'h1 << (k - 2) : 3'h0;
            @(posedge clk);
            done_pri_set <= 0; done_sec_set <= 0; tx_err_set <= 3'h0;
            tick(3);
            `CHK("tx irq", 1'b1, tx_irq)
            rd(OFF_CSR, k == 0 ? 32'h8020 : (k == 1 ? 32'hA0 : 32'h4020), "tx flag");
            if (k > 1) rd(OFF_TXERR, 32'h1 << (k - 2), "err reg");
            @(posedge clk);
            done_pri_clr <= (k == 0); done_sec_clr <= (k == 1);
            @(posedge clk);
            done_pri_clr <= 0; done_sec_clr <= 0;
            tick(3);
            rd(OFF_CSR, 32'h20, "tx flag clr");
            `CHK("tx irq off", 1'b0, tx_irq)
        end
        $display("test transmit irq done");
        apb(0, 8'h10, 32'h0);
        `CHK("unmapped err", 1'b1, e)
        `CHK("unmapped data", 32'h0, r)
        apb(1, OFF_CSR, 32'h38);
        @(posedge clk) init <= 1;
        @(posedge clk) init <= 0;
        rd(OFF_CSR, 32'h0, "csr init");
        $display("test bus and init done");
        give_verdict();
    end
endmodule
